// File: hw/slc_pkg.sv
// shared constants and types for the serial lane map control block
package slc_pkg;

    // register indices as printed; byte address is four times the index
    localparam logic [11:0] IDX_LANE_POWER_DOWN      = 12'h5b0;
    localparam logic [11:0] IDX_PHYS_LANE0_SELECT    = 12'h5b2;
    localparam logic [11:0] IDX_PHYS_LANE1_SELECT    = 12'h5b3;
    localparam logic [11:0] IDX_PHYS_LANE2_SELECT    = 12'h5b5;
    localparam logic [11:0] IDX_PHYS_LANE3_SELECT    = 12'h5b6;
    localparam logic [11:0] IDX_LANE_POLARITY_INVERT = 12'h5bf;

    localparam int          ADDR_W    = 16;
    localparam int          NUM_LANES = 4;
    localparam int          SEL_W     = 3;

    // reset values
    localparam logic [7:0] RST_LANE_POWER_DOWN      = 8'h00;
    localparam logic [2:0] RST_PHYS_LANE0_SELECT    = 3'h0;
    localparam logic [2:0] RST_PHYS_LANE1_SELECT    = 3'h1;
    localparam logic [2:0] RST_PHYS_LANE2_SELECT    = 3'h2;
    localparam logic [2:0] RST_PHYS_LANE3_SELECT    = 3'h3;
    localparam logic [7:0] RST_LANE_POLARITY_INVERT = 8'h00;

    // writable bits of the power-down register; per-lane bit is 2*lane
    localparam logic [7:0] MASK_LANE_POWER_DOWN = 8'h55;
    localparam int         LANE_BIT_STRIDE      = 2;

    // selector codes above this choose no logical lane
    localparam logic [2:0] SEL_MAX_CODE = 3'h3;

    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // per physical lane configuration
    typedef struct packed {
        logic             power_down;
        logic             invert;
        logic [SEL_W-1:0] select;
    } slc_lane_cfg_t;

    typedef struct packed {
        logic [1:0]  resp;
        logic [31:0] data;
    } slc_rd_ans_t;

endpackage : slc_pkg

// File: hw/slc_lane_slice.sv
// one physical output lane: crossbar pick, polarity and power-down
`timescale 1ns/100ps
`default_nettype none
module slc_lane_slice
    import slc_pkg::*;
#(
    parameter int LANE_W = 20
) (
    input  wire logic                              mclk,
    input  wire logic                              srst,
    input  wire logic [NUM_LANES-1:0][LANE_W-1:0] logical_lane_data,
    input  wire slc_lane_cfg_t                     cfg,
    output var  logic [LANE_W-1:0]                 lane_data,
    output var  logic                              lane_power_down
);

    logic [LANE_W-1:0] picked;

    // undefined selector codes give a zero word before inversion rather than aliasing
    always_comb begin
        picked = '0;
        if (cfg.select <= SEL_MAX_CODE) begin
            picked = logical_lane_data[cfg.select[1:0]];
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            lane_data       <= '0;
            lane_power_down <= 1'b0;
        end else begin
            lane_power_down <= cfg.power_down;
            if (cfg.power_down) begin
                lane_data <= '0;
            end else begin
                lane_data <= picked ^ {LANE_W{cfg.invert}};
            end
        end
    end

endmodule : slc_lane_slice
`default_nettype wire

// File: hw/slc_lane_map_top.sv
// register bank and lane crossbar for the four serial output lanes
`timescale 1ns/100ps
`default_nettype none
module slc_lane_map_top
    import slc_pkg::*;
#(
    parameter int LANE_W = 20
) (
    input  wire logic                              mclk,
    input  wire logic                              srst,
    input  wire logic [ADDR_W-1:0]                 s_axi_awaddr,
    input  wire logic                              s_axi_awvalid,
    output var  logic                              s_axi_awready,
    input  wire logic [31:0]                       s_axi_wdata,
    input  wire logic [3:0]                        s_axi_wstrb,
    input  wire logic                              s_axi_wvalid,
    output var  logic                              s_axi_wready,
    output var  logic [1:0]                        s_axi_bresp,
    output var  logic                              s_axi_bvalid,
    input  wire logic                              s_axi_bready,
    input  wire logic [ADDR_W-1:0]                 s_axi_araddr,
    input  wire logic                              s_axi_arvalid,
    output var  logic                              s_axi_arready,
    output var  logic [31:0]                       s_axi_rdata,
    output var  logic [1:0]                        s_axi_rresp,
    output var  logic                              s_axi_rvalid,
    input  wire logic                              s_axi_rready,
    input  wire logic [NUM_LANES-1:0][LANE_W-1:0] logical_lane_data,
    output var  logic [LANE_W-1:0]                 serial_out_lane_zero,
    output var  logic [LANE_W-1:0]                 serial_out_lane_one,
    output var  logic [LANE_W-1:0]                 serial_out_lane_two,
    output var  logic [LANE_W-1:0]                 serial_out_lane_three,
    output var  logic [NUM_LANES-1:0]              serial_out_lane_pd
);

    // register storage
    logic [7:0]                       lane_power_down;
    logic [NUM_LANES-1:0][SEL_W-1:0]  phys_lane_select;
    logic [7:0]                       lane_polarity_invert;

    // write channel holding state
    logic [ADDR_W-1:0]  aw_addr;
    logic               aw_full;
    logic [7:0]         w_byte;
    logic               w_lane0;
    logic               w_full;
    logic               do_write;
    logic [11:0]        wr_idx;
    logic               wr_hit;
    slc_rd_ans_t        next_rd;

    assign do_write = aw_full && w_full && !s_axi_bvalid;
    assign wr_idx   = aw_addr[13:2];

    always_comb begin
        unique case (wr_idx)
            IDX_LANE_POWER_DOWN, IDX_PHYS_LANE0_SELECT, IDX_PHYS_LANE1_SELECT,
            IDX_PHYS_LANE2_SELECT, IDX_PHYS_LANE3_SELECT,
            IDX_LANE_POLARITY_INVERT: wr_hit = (aw_addr[ADDR_W-1:14] == '0);
            default:                  wr_hit = 1'b0;
        endcase
    end

    // read decode; reserved selector bits read zero
    always_comb begin
        next_rd.resp = RESP_OKAY;
        next_rd.data = '0;
        if (s_axi_araddr[ADDR_W-1:14] != '0) begin
            next_rd.resp = RESP_SLVERR;
        end else begin
            unique case (s_axi_araddr[13:2])
                IDX_LANE_POWER_DOWN:      next_rd.data[7:0] = lane_power_down;
                IDX_PHYS_LANE0_SELECT:    next_rd.data[2:0] = phys_lane_select[0];
                IDX_PHYS_LANE1_SELECT:    next_rd.data[2:0] = phys_lane_select[1];
                IDX_PHYS_LANE2_SELECT:    next_rd.data[2:0] = phys_lane_select[2];
                IDX_PHYS_LANE3_SELECT:    next_rd.data[2:0] = phys_lane_select[3];
                IDX_LANE_POLARITY_INVERT: next_rd.data[7:0] = lane_polarity_invert;
                default:                  next_rd.resp = RESP_SLVERR;
            endcase
        end
    end

    // write address channel; one write in flight
    always_ff @(posedge mclk) begin
        if (srst) begin
            s_axi_awready <= 1'b1;
            aw_full       <= 1'b0;
            aw_addr       <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_full       <= 1'b1;
            aw_addr       <= s_axi_awaddr;
        end else if (do_write) begin
            aw_full <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
        end
    end

    // write data channel; only the low byte lane carries register data
    always_ff @(posedge mclk) begin
        if (srst) begin
            s_axi_wready <= 1'b1;
            w_full       <= 1'b0;
            w_byte       <= '0;
            w_lane0      <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_full       <= 1'b1;
            w_byte       <= s_axi_wdata[7:0];
            w_lane0      <= s_axi_wstrb[0];
        end else if (do_write) begin
            w_full <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_wready <= 1'b1;
        end
    end

    // write response
    always_ff @(posedge mclk) begin
        if (srst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // power-down register; reserved odd bits stay zero
    always_ff @(posedge mclk) begin
        if (srst) begin
            lane_power_down <= RST_LANE_POWER_DOWN;
        end else if (do_write && wr_hit && w_lane0 && wr_idx == IDX_LANE_POWER_DOWN) begin
            lane_power_down <= w_byte & MASK_LANE_POWER_DOWN;
        end
    end

    // lane selectors
    always_ff @(posedge mclk) begin
        if (srst) begin
            phys_lane_select[0] <= RST_PHYS_LANE0_SELECT;
            phys_lane_select[1] <= RST_PHYS_LANE1_SELECT;
            phys_lane_select[2] <= RST_PHYS_LANE2_SELECT;
            phys_lane_select[3] <= RST_PHYS_LANE3_SELECT;
        end else if (do_write && wr_hit && w_lane0) begin
            unique case (wr_idx)
                IDX_PHYS_LANE0_SELECT: phys_lane_select[0] <= w_byte[2:0];
                IDX_PHYS_LANE1_SELECT: phys_lane_select[1] <= w_byte[2:0];
                IDX_PHYS_LANE2_SELECT: phys_lane_select[2] <= w_byte[2:0];
                IDX_PHYS_LANE3_SELECT: phys_lane_select[3] <= w_byte[2:0];
                default: ;
            endcase
        end
    end

    // polarity register; reserved bits are plain storage
    always_ff @(posedge mclk) begin
        if (srst) begin
            lane_polarity_invert <= RST_LANE_POLARITY_INVERT;
        end else if (do_write && wr_hit && w_lane0 && wr_idx == IDX_LANE_POLARITY_INVERT) begin
            lane_polarity_invert <= w_byte;
        end
    end

    // read channel: answer one cycle after the address is taken
    always_ff @(posedge mclk) begin
        if (srst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= next_rd.data;
            s_axi_rresp   <= next_rd.resp;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // lane datapath; config changes mid-frame corrupt data, software must idle link
    logic [NUM_LANES-1:0][LANE_W-1:0] lane_out;

    for (genvar g = 0; g < NUM_LANES; g++) begin : g_lane
        slc_lane_cfg_t cfg;
        assign cfg.power_down = lane_power_down[g*LANE_BIT_STRIDE];
        assign cfg.invert     = lane_polarity_invert[g*LANE_BIT_STRIDE];
        assign cfg.select     = phys_lane_select[g];

        slc_lane_slice #(
            .LANE_W (LANE_W)
        ) u_slice (
            .mclk              (mclk),
            .srst              (srst),
            .logical_lane_data (logical_lane_data),
            .cfg               (cfg),
            .lane_data         (lane_out[g]),
            .lane_power_down   (serial_out_lane_pd[g])
        );
    end

    assign serial_out_lane_zero  = lane_out[0];
    assign serial_out_lane_one   = lane_out[1];
    assign serial_out_lane_two   = lane_out[2];
    assign serial_out_lane_three = lane_out[3];

endmodule : slc_lane_map_top
`default_nettype wire

// File: verification/slc_lane_map_asserts.sv
// port-level assertions for the lane map block
`timescale 1ns/100ps
`default_nettype none
module slc_lane_map_asserts
    import slc_pkg::*;
#(
    parameter int LANE_W = 20
) (
    input wire logic              mclk,
    input wire logic              srst,
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready,
    input wire logic [1:0]        s_axi_bresp,
    input wire logic [31:0]       s_axi_rdata,
    input wire logic [LANE_W-1:0] serial_out_lane_zero,
    input wire logic [LANE_W-1:0] serial_out_lane_three,
    input wire logic [3:0]        serial_out_lane_pd
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    // a dead lane must not leak stale words to the receiver
    property p_pd0; serial_out_lane_pd[0] |-> serial_out_lane_zero == '0; endproperty
    a_pd0: assert property (p_pd0) else $error("lane 0 data while powered down");
    property p_pd3; serial_out_lane_pd[3] |-> serial_out_lane_three == '0; endproperty
    a_pd3: assert property (p_pd3) else $error("lane 3 data while powered down");
    property p_pd_rst; $past(srst) |-> serial_out_lane_pd == 4'h0; endproperty
    a_pd_rst: assert property (p_pd_rst) else $error("lane powered down after reset");
    property p_wr; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid; endproperty
    a_wr: assert property (p_wr) else $error("write response missing");
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bhold: assert property (p_bhold) else $error("write response dropped");
    property p_rlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[31:8] == '0;
    endproperty
    a_rlat: assert property (p_rlat) else $error("read answer late or upper bits set");
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read data dropped");
    property p_ref; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    a_ref: assert property (p_ref) else $error("write taken with response pending");
endmodule : slc_lane_map_asserts
bind slc_lane_map_top slc_lane_map_asserts #(.LANE_W(LANE_W)) u_chk (
    .mclk                  (mclk),
    .srst                  (srst),
    .s_axi_awvalid         (s_axi_awvalid),
    .s_axi_awready         (s_axi_awready),
    .s_axi_wvalid          (s_axi_wvalid),
    .s_axi_wready          (s_axi_wready),
    .s_axi_bvalid          (s_axi_bvalid),
    .s_axi_bready          (s_axi_bready),
    .s_axi_arvalid         (s_axi_arvalid),
    .s_axi_arready         (s_axi_arready),
    .s_axi_rvalid          (s_axi_rvalid),
    .s_axi_rready          (s_axi_rready),
    .s_axi_bresp           (s_axi_bresp),
    .s_axi_rdata           (s_axi_rdata),
    .serial_out_lane_zero  (serial_out_lane_zero),
    .serial_out_lane_three (serial_out_lane_three),
    .serial_out_lane_pd    (serial_out_lane_pd)
);
`default_nettype wire

// File: verification/slc_rx_model.sv
// receiver-side model of the four physical lanes
`timescale 1ns/100ps
`default_nettype none
module slc_rx_model #(
    parameter int LANE_W = 20
) (
    input  wire logic                   mclk,
    input  wire logic [3:0][LANE_W-1:0] lane_word,
    input  wire logic [3:0]             lane_pd,
    output var  logic [3:0][LANE_W-1:0] rx_word,
    output var  logic [3:0]             rx_down
);
    // a powered-down lane gives no word to trust, so show a changing pattern
    always_ff @(posedge mclk) begin
        for (int g = 0; g < 4; g++) begin
            rx_down[g] <= lane_pd[g];
            rx_word[g] <= lane_pd[g] ? ~rx_word[g] : lane_word[g];
        end
    end
endmodule : slc_rx_model
`default_nettype wire

// File: verification/tb_serial_lane_map_control.sv
// register and lane map tests for the serial lane map block
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin mismatches++; \
    $display("Error %s expected %h seen %h", n, e, s); end end
module tb_serial_lane_map_control
    import slc_pkg::*;
;
    localparam int LW = 20;
    logic mclk = 0, srst = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
    logic awr, wrd, bv, arr, rv, a;
    logic [15:0] awa = '0, ara = '0;
    logic [31:0] wd = '0, rd, rdv;
    logic [1:0] bres, rres, rsp;
    logic [3:0][LW-1:0] ld = {20'h3c3c3, 20'ha5a51, 20'h0f0f2, 20'h12345}, so, rxw;
    logic [3:0] pd, rxd;
    logic [2:0] sel [4] = '{3'h0, 3'h1, 3'h2, 3'h3};
    logic [7:0] inv = 8'h00, pdr = 8'h00;
    logic [11:0] sx [4] = '{IDX_PHYS_LANE0_SELECT, IDX_PHYS_LANE1_SELECT,
                            IDX_PHYS_LANE2_SELECT, IDX_PHYS_LANE3_SELECT};
    int mismatches = 0, n_tests = 0;
    slc_lane_map_top #(.LANE_W(LW)) u_dut (.mclk(mclk), .srst(srst), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bres), .s_axi_bvalid(bv),
        .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rd), .s_axi_rresp(rres), .s_axi_rvalid(rv), .s_axi_rready(rry),
        .logical_lane_data(ld), .serial_out_lane_zero(so[0]), .serial_out_lane_one(so[1]),
        .serial_out_lane_two(so[2]), .serial_out_lane_three(so[3]), .serial_out_lane_pd(pd));
    slc_rx_model #(.LANE_W(LW)) u_rx (.mclk(mclk), .lane_word(so), .lane_pd(pd),
        .rx_word(rxw), .rx_down(rxd));
    initial forever #50 mclk = ~mclk;
    task automatic wr(input logic [11:0] ix, input logic [7:0] d, input logic [1:0] er);
        logic ga, gw, w;
        ga = 0;
        gw = 0;
        awa <= {2'b0, ix, 2'b0};
        wd <= {24'h0, d};
        awv <= 1;
        wv <= 1;
        while (!(ga && gw)) begin
            @(negedge mclk);
            a = awv && awr;
            w = wv && wrd;
            @(posedge mclk);
            if (a) awv <= 0;
            if (w) wv <= 0;
            ga |= a;
            gw |= w;
        end
        do begin @(negedge mclk); a = bv; @(posedge mclk); end while (!a);
        bry <= 1; // late ready makes the response stand a cycle
        @(negedge mclk);
        rsp = bres;
        @(posedge mclk);
        bry <= 0;
        `CHK("bresp", er, rsp)
    endtask : wr
    task automatic rdc(input logic [11:0] ix, input logic [31:0] e, input logic [1:0] er);
        ara <= {2'b0, ix, 2'b0};
        arv <= 1;
        do begin @(negedge mclk); a = arr; @(posedge mclk); end while (!a);
        arv <= 0;
        do begin @(negedge mclk); a = rv; @(posedge mclk); end while (!a);
        rry <= 1; // late ready makes the answer stand a cycle
        @(negedge mclk);
        rdv = rd;
        rsp = rres;
        @(posedge mclk);
        rry <= 0;
        `CHK("rdata", e, rdv)
        `CHK("rresp", er, rsp)
    endtask : rdc
    task automatic lanes();
        logic [LW-1:0] ew;
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        for (int g = 0; g < 4; g++) begin
            `CHK("lane_pd", pdr[2*g], rxd[g])
            // codes past the last logical lane give a zero word before inversion
            ew = (sel[g] <= SEL_MAX_CODE) ? ld[sel[g][1:0]] : '0;
            if (!pdr[2*g]) `CHK("lane_word", ew ^ {LW{inv[2*g]}}, rxw[g])
        end
        @(posedge mclk);
    endtask : lanes
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim
    initial begin
        #500000;
        mismatches++;
        end_sim();
    end
    initial begin
        repeat (3) @(posedge mclk);
        srst <= 0;
        rdc(IDX_LANE_POWER_DOWN, 0, RESP_OKAY);
        for (int g = 0; g < 4; g++) rdc(sx[g], g, RESP_OKAY);
        rdc(IDX_LANE_POLARITY_INVERT, 0, RESP_OKAY);
        lanes();
        // reconfigure only with static lane data, each rotation a distinct map
        for (int k = 1; k < 4; k++) begin
            for (int g = 0; g < 4; g++) begin
                sel[g] = 3'((g + k) % 4);
                wr(sx[g], {5'h0, sel[g]}, RESP_OKAY);
            end
            lanes();
        end
        for (int g = 0; g < 5; g++) begin
            inv = (g == 4) ? 8'hff : 8'h01 << (2 * g);
            wr(IDX_LANE_POLARITY_INVERT, inv, RESP_OKAY);
            lanes();
        end
        rdc(IDX_LANE_POLARITY_INVERT, 32'hff, RESP_OKAY);
        for (int g = 0; g < 4; g++) begin
            pdr = 8'h01 << (2 * g);
            wr(IDX_LANE_POWER_DOWN, pdr, RESP_OKAY);
            lanes();
        end
        pdr = 8'h55;
        wr(IDX_LANE_POWER_DOWN, 8'hff, RESP_OKAY);
        rdc(IDX_LANE_POWER_DOWN, 32'h55, RESP_OKAY);
        lanes();
        sel[1] = 3'h7;
        wr(sx[1], 8'hff, RESP_OKAY);
        rdc(sx[1], 32'h7, RESP_OKAY);
        pdr = 8'h00;
        wr(IDX_LANE_POWER_DOWN, pdr, RESP_OKAY);
        lanes();
        wr(12'h5b1, 8'h01, RESP_SLVERR);
        rdc(12'h5b1, 0, RESP_SLVERR);
        end_sim();
    end
endmodule : tb_serial_lane_map_control
`default_nettype wire
